// *** verilog/pic_primary_irq.v ***
/*
 * primary interrupt control: edge selection for two external pins,
 * request flags and enables for pins, three multi-function groups, two
 * tick sources, low supply and conversion, a global enable, and a sticky
 * event status block with its own interrupt output.
 * assumes: one clock, synchronous active-high reset, pins and source
 * pulses synchronous to core_clk, an AXI4-Lite master on the bus side.
 */
// Function
// - pin a edge select bits 1:0
// - pin b edge select bits 3:2
// - edge select bits 7:4 read zero
// - control register a bit 7 reads zero
// - global enable gates every core request, not evt_irq
// - pin flags set on selected edge
// - pin enables block pin requests
// - group zero flag in bit six
// - group zero enable in bit three
// - group flag set by its one source pulse
`timescale 1ns/1ps
`default_nettype none
`include "pic_primary_regs.vh"

module pic_primary_irq (
    input  wire                      core_clk,
    input  wire                      srst,
    // axi4-lite write address
    input  wire [`PIC_ADDR_W-1:0]    s_axi_awaddr,
    input  wire                      s_axi_awvalid,
    output reg                       s_axi_awready,
    // axi4-lite write data
    input  wire [`PIC_DATA_W-1:0]    s_axi_wdata,
    input  wire [3:0]                s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output reg                       s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]                s_axi_bresp,
    output reg                       s_axi_bvalid,
    input  wire                      s_axi_bready,
    // axi4-lite read address
    input  wire [`PIC_ADDR_W-1:0]    s_axi_araddr,
    input  wire                      s_axi_arvalid,
    output reg                       s_axi_arready,
    // axi4-lite read data
    output reg  [`PIC_DATA_W-1:0]    s_axi_rdata,
    output reg  [1:0]                s_axi_rresp,
    output reg                       s_axi_rvalid,
    input  wire                      s_axi_rready,
    // external interrupt pins
    input  wire                      ext_irq_pin_a,
    input  wire                      ext_irq_pin_b,
    // one-cycle request pulses from internal sources
    input  wire                      group_zero_src,
    input  wire                      group_one_src,
    input  wire                      group_two_src,
    input  wire                      tick_a_src,
    input  wire                      tick_b_src,
    input  wire                      low_supply_src,
    input  wire                      conversion_src,
    // requests to the core
    output reg                       core_irq_req,
    output reg  [`PIC_NSRC-1:0]      core_irq_pend,
    // event status interrupt
    output reg                       evt_irq
);

    // register storage
    reg  [7:0]               edge_sel_ff;   // pin edge selectors
    reg  [7:0]               ctrl_a_ff;     // global, pin and group 0
    reg  [7:0]               ctrl_b_ff;     // groups 1-2, ticks
    reg  [7:0]               ctrl_c_ff;     // low supply, conversion
    reg  [`PIC_NSRC-1:0]     evt_stat_ff;   // sticky event status
    reg  [`PIC_NSRC-1:0]     evt_en_ff;     // event interrupt enables

    // pin edge detection state
    reg  [1:0]               pin_prev_ff;   // last sampled pin levels
    reg                      pin_ok_ff;     // previous sample is valid

    // write channel state
    reg                      aw_got_ff;     // write address held
    reg                      w_got_ff;      // write data held
    reg  [`PIC_ADDR_W-1:0]   awaddr_ff;     // held write address
    reg  [`PIC_DATA_W-1:0]   wdata_ff;      // held write data
    reg  [3:0]               wstrb_ff;      // held byte strobes

    // combinational signals
    wire [1:0]               pin_now;       // current pin levels
    wire [1:0]               pin_edge;      // selected edge seen per pin
    wire [`PIC_NSRC-1:0]     src_set;       // flag set events
    wire [`PIC_NSRC-1:0]     src_flag;      // request flags in order
    wire [`PIC_NSRC-1:0]     src_en;        // individual enables
    wire                     wr_fire;       // write performed this cycle
    wire [`PIC_ADDR_W-1:0]   wr_word;       // aligned write address
    wire [`PIC_ADDR_W-1:0]   rd_word;       // aligned read address
    wire                     wr_lane0;      // low byte written
    wire                     wr_lane1;      // second byte written
    reg                      wr_hit;        // write address mapped
    reg  [`PIC_DATA_W-1:0]   rd_mux;        // read data
    reg                      rd_hit;        // read address mapped
    reg  [7:0]               nxt_edge_sel;
    reg  [7:0]               nxt_ctrl_a;
    reg  [7:0]               nxt_ctrl_b;
    reg  [7:0]               nxt_ctrl_c;
    reg  [`PIC_NSRC-1:0]     nxt_evt_stat;
    reg  [`PIC_NSRC-1:0]     nxt_evt_en;

    assign pin_now  = {ext_irq_pin_b, ext_irq_pin_a};
    assign wr_fire  = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    assign wr_word  = {awaddr_ff[`PIC_ADDR_W-1:2], 2'h0};
    assign rd_word  = {s_axi_araddr[`PIC_ADDR_W-1:2], 2'h0};
    assign wr_lane0 = wstrb_ff[0];
    assign wr_lane1 = wstrb_ff[1];

    // per-pin edge detector, selector pair 2*i+1:2*i
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            wire [1:0] sel;
            wire       rise;
            wire       fall;
            assign sel  = edge_sel_ff[2*gi+1:2*gi];
            assign rise = pin_ok_ff & pin_now[gi] & ~pin_prev_ff[gi];
            assign fall = pin_ok_ff & ~pin_now[gi] & pin_prev_ff[gi];
            // 00 off, 01 rising, 10 falling, 11 both
            assign pin_edge[gi] =
                ((sel == `PIC_EDGE_RISE) & rise) |
                ((sel == `PIC_EDGE_FALL) & fall) |
                ((sel == `PIC_EDGE_BOTH) & (rise | fall));
        end
    endgenerate

    // sources in order: pin a, pin b, group 0, tick a, tick b,
    // group 1, group 2, conversion, low supply
    assign src_set = {low_supply_src, conversion_src, group_two_src,
                      group_one_src, tick_b_src, tick_a_src,
                      group_zero_src, pin_edge};
    assign src_flag = {ctrl_c_ff[5], ctrl_c_ff[4], ctrl_b_ff[7],
                       ctrl_b_ff[6], ctrl_b_ff[5], ctrl_b_ff[4],
                       ctrl_a_ff[`PIC_A_GRP0_FLAG],
                       ctrl_a_ff[`PIC_A_PIN_B_FLAG],
                       ctrl_a_ff[`PIC_A_PIN_A_FLAG]};
    assign src_en = {ctrl_c_ff[1], ctrl_c_ff[0], ctrl_b_ff[3],
                     ctrl_b_ff[2], ctrl_b_ff[1], ctrl_b_ff[0],
                     ctrl_a_ff[`PIC_A_GRP0_EN],
                     ctrl_a_ff[`PIC_A_PIN_B_EN],
                     ctrl_a_ff[`PIC_A_PIN_A_EN]};

    // write decode: every mapped offset answers okay
    always @* begin
        if (wr_word == `PIC_OFS_EDGE_SEL || wr_word == `PIC_OFS_CTRL_A ||
            wr_word == `PIC_OFS_CTRL_B || wr_word == `PIC_OFS_CTRL_C) begin
            wr_hit = 1'b1;
        end else if (wr_word == `PIC_OFS_EVT_STAT) begin
            wr_hit = 1'b1;                  // read-only, write ignored
        end else if (wr_word == `PIC_OFS_EVT_CLR ||
                     wr_word == `PIC_OFS_EVT_EN) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;                  // unmapped
        end
    end

    // next register values: software write first, hardware set wins
    always @* begin
        nxt_edge_sel = edge_sel_ff;
        nxt_ctrl_a   = ctrl_a_ff;
        nxt_ctrl_b   = ctrl_b_ff;
        nxt_ctrl_c   = ctrl_c_ff;
        nxt_evt_stat = evt_stat_ff;
        nxt_evt_en   = evt_en_ff;
        if (wr_fire && wr_lane0) begin
            if (wr_word == `PIC_OFS_EDGE_SEL) begin
                nxt_edge_sel = wdata_ff[7:0] & `PIC_MASK_EDGE_SEL;
            end else if (wr_word == `PIC_OFS_CTRL_A) begin
                nxt_ctrl_a = wdata_ff[7:0] & `PIC_MASK_CTRL_A;
            end else if (wr_word == `PIC_OFS_CTRL_B) begin
                nxt_ctrl_b = wdata_ff[7:0] & `PIC_MASK_CTRL_B;
            end else if (wr_word == `PIC_OFS_CTRL_C) begin
                nxt_ctrl_c = wdata_ff[7:0] & `PIC_MASK_CTRL_C;
            end else if (wr_word == `PIC_OFS_EVT_CLR) begin
                nxt_evt_stat[7:0] = evt_stat_ff[7:0] & ~wdata_ff[7:0];
            end else if (wr_word == `PIC_OFS_EVT_EN) begin
                nxt_evt_en[7:0] = wdata_ff[7:0];
            end
        end
        if (wr_fire && wr_lane1) begin
            if (wr_word == `PIC_OFS_EVT_CLR) begin
                nxt_evt_stat[8] = evt_stat_ff[8] & ~wdata_ff[8];
            end else if (wr_word == `PIC_OFS_EVT_EN) begin
                nxt_evt_en[8] = wdata_ff[8];
            end
        end
        // hardware sets override a clear in the same cycle
        nxt_ctrl_a[`PIC_A_PIN_A_FLAG] = nxt_ctrl_a[`PIC_A_PIN_A_FLAG]
                                        | src_set[0];
        nxt_ctrl_a[`PIC_A_PIN_B_FLAG] = nxt_ctrl_a[`PIC_A_PIN_B_FLAG]
                                        | src_set[1];
        nxt_ctrl_a[`PIC_A_GRP0_FLAG]  = nxt_ctrl_a[`PIC_A_GRP0_FLAG]
                                        | src_set[2];
        nxt_ctrl_b[4] = nxt_ctrl_b[4] | src_set[3];
        nxt_ctrl_b[5] = nxt_ctrl_b[5] | src_set[4];
        nxt_ctrl_b[6] = nxt_ctrl_b[6] | src_set[5];
        nxt_ctrl_b[7] = nxt_ctrl_b[7] | src_set[6];
        nxt_ctrl_c[4] = nxt_ctrl_c[4] | src_set[7];
        nxt_ctrl_c[5] = nxt_ctrl_c[5] | src_set[8];
        nxt_evt_stat  = nxt_evt_stat | src_set;
    end

    // register update and pin sampling
    always @(posedge core_clk) begin
        if (srst) begin
            edge_sel_ff <= `PIC_RST_EDGE_SEL;
            ctrl_a_ff   <= `PIC_RST_CTRL_A;
            ctrl_b_ff   <= `PIC_RST_CTRL_B;
            ctrl_c_ff   <= `PIC_RST_CTRL_C;
            evt_stat_ff <= `PIC_RST_EVT;
            evt_en_ff   <= `PIC_RST_EVT;
            pin_prev_ff <= 2'h0;
            pin_ok_ff   <= 1'b0;
        end else begin
            edge_sel_ff <= nxt_edge_sel;
            ctrl_a_ff   <= nxt_ctrl_a;
            ctrl_b_ff   <= nxt_ctrl_b;
            ctrl_c_ff   <= nxt_ctrl_c;
            evt_stat_ff <= nxt_evt_stat;
            evt_en_ff   <= nxt_evt_en;
            pin_prev_ff <= pin_now;
            pin_ok_ff   <= 1'b1;            // no edge on first sample
        end
    end

    // request outputs to the core and the event interrupt
    always @(posedge core_clk) begin
        if (srst) begin
            core_irq_req  <= 1'b0;
            core_irq_pend <= {`PIC_NSRC{1'b0}};
            evt_irq       <= 1'b0;
        end else begin
            // flag, enable and global enable all needed
            core_irq_pend <= src_flag & src_en &
                {`PIC_NSRC{ctrl_a_ff[`PIC_A_GLOBAL_EN]}};
            core_irq_req  <= ctrl_a_ff[`PIC_A_GLOBAL_EN] &
                             (|(src_flag & src_en));
            evt_irq       <= |(evt_stat_ff & evt_en_ff);
        end
    end

    // write channel: address and data taken in either order
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PIC_RESP_OKAY;
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            awaddr_ff     <= {`PIC_ADDR_W{1'b0}};
            wdata_ff      <= {`PIC_DATA_W{1'b0}};
            wstrb_ff      <= 4'h0;
        end else begin
            // capture address
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff     <= s_axi_awaddr;
                aw_got_ff     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            // capture data
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                w_got_ff     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // both held: write done, answer
            if (wr_fire) begin
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
            end
            // response taken: reopen both channels
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read decode and data assembly
    always @* begin
        rd_mux = {`PIC_DATA_W{1'b0}};
        rd_hit = 1'b1;
        if (rd_word == `PIC_OFS_EDGE_SEL) begin
            rd_mux[7:0] = edge_sel_ff & `PIC_MASK_EDGE_SEL;
        end else if (rd_word == `PIC_OFS_CTRL_A) begin
            rd_mux[7:0] = ctrl_a_ff & `PIC_MASK_CTRL_A;
        end else if (rd_word == `PIC_OFS_CTRL_B) begin
            rd_mux[7:0] = ctrl_b_ff;
        end else if (rd_word == `PIC_OFS_CTRL_C) begin
            rd_mux[7:0] = ctrl_c_ff & `PIC_MASK_CTRL_C;
        end else if (rd_word == `PIC_OFS_EVT_STAT) begin
            rd_mux[`PIC_NSRC-1:0] = evt_stat_ff;
        end else if (rd_word == `PIC_OFS_EVT_CLR) begin
            rd_mux = {`PIC_DATA_W{1'b0}};   // write-only, reads zero
        end else if (rd_word == `PIC_OFS_EVT_EN) begin
            rd_mux[`PIC_NSRC-1:0] = evt_en_ff;
        end else begin
            rd_hit = 1'b0;                  // unmapped, zero data
        end
    end

    // read channel: answer on the edge that takes the address
    always @(posedge core_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= {`PIC_DATA_W{1'b0}};
            s_axi_rresp   <= `PIC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_hit ? `PIC_RESP_OKAY : `PIC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // pic_primary_irq
`default_nettype wire

// *** verilog/pic_primary_regs.vh ***
/*
 * register map, field positions, reset values and bus constants for the
 * primary interrupt control block.
 * assumes: included by the block's design file, checker and bench; word-aligned
 * AXI4-Lite accesses with byte addresses.
 */
`ifndef PIC_PRIMARY_REGS_VH
`define PIC_PRIMARY_REGS_VH

// byte addresses of the registers
`define PIC_OFS_EDGE_SEL   8'h00
`define PIC_OFS_CTRL_A     8'h04
`define PIC_OFS_CTRL_B     8'h08
`define PIC_OFS_CTRL_C     8'h0c
`define PIC_OFS_EVT_STAT   8'h10
`define PIC_OFS_EVT_CLR    8'h14
`define PIC_OFS_EVT_EN     8'h18

// bus widths
`define PIC_ADDR_W         8
`define PIC_DATA_W         32
`define PIC_NSRC           9

// writable bit masks (unimplemented bits read zero)
`define PIC_MASK_EDGE_SEL  8'h0f
`define PIC_MASK_CTRL_A    8'h7f
`define PIC_MASK_CTRL_B    8'hff
`define PIC_MASK_CTRL_C    8'h33

// reset values
`define PIC_RST_EDGE_SEL   8'h00
`define PIC_RST_CTRL_A     8'h00
`define PIC_RST_CTRL_B     8'h00
`define PIC_RST_CTRL_C     8'h00
`define PIC_RST_EVT        9'h000

// edge selector encoding
`define PIC_EDGE_OFF       2'h0
`define PIC_EDGE_RISE      2'h1
`define PIC_EDGE_FALL      2'h2
`define PIC_EDGE_BOTH      2'h3

// field positions in control register a
`define PIC_A_GLOBAL_EN    0
`define PIC_A_PIN_A_EN     1
`define PIC_A_PIN_B_EN     2
`define PIC_A_GRP0_EN      3
`define PIC_A_PIN_A_FLAG   4
`define PIC_A_PIN_B_FLAG   5
`define PIC_A_GRP0_FLAG    6

// axi responses
`define PIC_RESP_OKAY      2'h0
`define PIC_RESP_SLVERR    2'h2

`endif

// *** test/pic_primary_irq_checker.sv ***
/* port checker for the primary interrupt control block.
   assumes: bound to pic_primary_irq, one clock, srst synchronous high. */
`timescale 1ns/1ps
`default_nettype none
`include "pic_primary_regs.vh"
module pic_primary_irq_checker (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        core_irq_req,
    input wire logic [8:0]  core_irq_pend,
    input wire logic        evt_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // summary request agrees with the gated per-source vector
    AST_REQ_SUM: assert property (core_irq_req == |core_irq_pend)
        else $error("core request disagrees with pending vector");
    // reset leaves nothing requested
    AST_RST_QUIET: assert property (disable iff (1'b0) srst |=>
        !core_irq_req && core_irq_pend == 9'h000 && !evt_irq)
        else $error("request seen right after reset");
    // a write taken on both channels is answered two edges later
    AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    // a taken read is answered on the next edge
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read not answered");
    // write answer stands until taken
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped or changed");
    // read answer stands until taken
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped or changed");
    // read data above bit 8 is zero
    AST_R_UPPER: assert property (s_axi_rvalid |->
        s_axi_rdata[31:9] == 23'h0)
        else $error("upper read bits not zero");
    // no new write is taken while an answer is pending
    AST_NO_NEW_W: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write channels ready during answer");
    // a taken answer is withdrawn on the next edge
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    cover property ($rose(core_irq_req));
    cover property ($rose(evt_irq));
    cover property (s_axi_rvalid && s_axi_rresp == `PIC_RESP_SLVERR);
endmodule // pic_primary_irq_checker
bind pic_primary_irq pic_primary_irq_checker u_pic_primary_irq_checker (
    .core_clk(core_clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .core_irq_req(core_irq_req), .core_irq_pend(core_irq_pend),
    .evt_irq(evt_irq));
`default_nettype wire

// *** test/pic_pin_model.sv ***
/* pin-side partner: drives the two external interrupt pins.
   assumes: levels chosen by the bench, applied just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module pic_pin_model (
    input  wire logic       core_clk,
    input  wire logic [1:0] want_lvl,
    output var  logic       ext_irq_pin_a,
    output var  logic       ext_irq_pin_b
);
    // pins idle low, then follow the requested level on each edge
    initial begin
        ext_irq_pin_a = 1'b0;
        ext_irq_pin_b = 1'b0;
    end
    always @(posedge core_clk) begin
        ext_irq_pin_a <= want_lvl[0];
        ext_irq_pin_b <= want_lvl[1];
    end
endmodule // pic_pin_model
`default_nettype wire

// *** test/pic_primary_irq_tb.sv ***
/* self-checking bench for the primary interrupt control block.
   assumes: design and header on the include path, checker bound. */
`timescale 1ns/1ps
`default_nettype none
`include "pic_primary_regs.vh"
module pic_primary_irq_tb;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [6:0]  src_vec = 7'h00;   // internal source pulses
    logic [1:0]  want_lvl = 2'h0;   // requested pin levels
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, core_irq_req, evt_irq, pin_a, pin_b;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [8:0]  core_irq_pend;
    int          err_count = 0;
    int          check_count = 0;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [7:0]  m_adr [4] = '{`PIC_OFS_EDGE_SEL, `PIC_OFS_CTRL_A,
                              `PIC_OFS_CTRL_B, `PIC_OFS_CTRL_C};
    logic [31:0] m_val [4] = '{32'h0f, 32'h7f, 32'hff, 32'h33};
    always #10 core_clk = ~core_clk;
    pic_primary_irq u_pic_primary_irq (
        .core_clk(core_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
        .group_zero_src(src_vec[0]), .tick_a_src(src_vec[1]),
        .tick_b_src(src_vec[2]), .group_one_src(src_vec[3]),
        .group_two_src(src_vec[4]), .conversion_src(src_vec[5]),
        .low_supply_src(src_vec[6]), .core_irq_req(core_irq_req),
        .core_irq_pend(core_irq_pend), .evt_irq(evt_irq));
    pic_pin_model u_pic_pin_model (.core_clk(core_clk), .want_lvl(want_lvl),
        .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b));
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    // one write: both channels offered, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) begin
            err_count++;
            results();
        end
        s_axi_bready <= 1'b0;
        chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge core_clk);
    endtask
    // one read: address held until taken, data taken with rvalid
    task automatic axi_rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) begin
            err_count++;
            results();
        end
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        axi_rd(a);
        chk(nm, exp, rd_data);
        chk("read response", 32'h0, {30'h0, rd_resp});
    endtask
    // one-cycle source pulse, then settle
    task automatic pulse(input int i);
        src_vec <= 7'h01 << i;
        @(posedge core_clk);
        src_vec <= 7'h00;
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 7; i++) rd_chk("reset value", 8'(i * 4), 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            axi_wr(m_adr[i], 32'hffffffff, `PIC_RESP_OKAY);
            rd_chk("implemented bits", m_adr[i], m_val[i]);
        end
        chk("pending all", 32'h1ff, {23'h0, core_irq_pend});
        chk("request", 32'h1, {31'h0, core_irq_req});
        axi_wr(`PIC_OFS_CTRL_A, 32'h7e, `PIC_RESP_OKAY);
        chk("pending gated", 32'h0, {23'h0, core_irq_pend});
        chk("request gated", 32'h0, {31'h0, core_irq_req});
        for (int i = 0; i < 4; i++) axi_wr(m_adr[i], 32'h0, `PIC_RESP_OKAY);
        axi_wr(8'h1c, 32'hff, `PIC_RESP_SLVERR);
        axi_rd(8'h1c);
        chk("unmapped response", 32'h2, {30'h0, rd_resp});
        chk("unmapped data", 32'h0, rd_data);
        $display("test masks done");
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                axi_wr(`PIC_OFS_EDGE_SEL, 32'(m) << (2 * p), `PIC_RESP_OKAY);
                axi_wr(`PIC_OFS_CTRL_A, 32'h1 | (32'h2 << p), `PIC_RESP_OKAY);
                want_lvl[p] <= 1'b1;
                repeat (4) @(posedge core_clk);
                rd_chk("rise flag", `PIC_OFS_CTRL_A, 32'h1 | (32'h2 << p) |
                       (m[0] ? 32'h10 << p : 32'h0));
                chk("rise pend", m[0] ? 32'h1 << p : 32'h0,
                    {23'h0, core_irq_pend});
                axi_wr(`PIC_OFS_CTRL_A, 32'h1 | (32'h2 << p), `PIC_RESP_OKAY);
                want_lvl[p] <= 1'b0;
                repeat (4) @(posedge core_clk);
                rd_chk("fall flag", `PIC_OFS_CTRL_A, 32'h1 | (32'h2 << p) |
                       (m[1] ? 32'h10 << p : 32'h0));
            end
        end
        axi_wr(`PIC_OFS_EDGE_SEL, 32'hf, `PIC_RESP_OKAY);
        axi_wr(`PIC_OFS_CTRL_A, 32'h1, `PIC_RESP_OKAY);
        want_lvl <= 2'h3;
        repeat (4) @(posedge core_clk);
        rd_chk("pin flags held off", `PIC_OFS_CTRL_A, 32'h31);
        chk("pin enables off", 32'h0, {23'h0, core_irq_pend});
        $display("test edges done");
        axi_wr(`PIC_OFS_CTRL_A, 32'h1, `PIC_RESP_OKAY);
        pulse(0);
        rd_chk("group zero flag", `PIC_OFS_CTRL_A, 32'h41);
        chk("group zero blocked", 32'h0, {23'h0, core_irq_pend});
        axi_wr(`PIC_OFS_CTRL_A, 32'h49, `PIC_RESP_OKAY);
        chk("group zero pend", 32'h4, {23'h0, core_irq_pend});
        axi_wr(`PIC_OFS_CTRL_A, 32'h0, `PIC_RESP_OKAY);
        $display("test group done");
        axi_wr(`PIC_OFS_EVT_CLR, 32'h1ff, `PIC_RESP_OKAY);
        rd_chk("status cleared", `PIC_OFS_EVT_STAT, 32'h0);
        for (int i = 0; i < 7; i++) begin
            pulse(i);
            axi_wr(`PIC_OFS_EVT_STAT, 32'h0, `PIC_RESP_OKAY);
            rd_chk("status set", `PIC_OFS_EVT_STAT, 32'h4 << i);
            chk("event masked", 32'h0, {31'h0, evt_irq});
            axi_wr(`PIC_OFS_EVT_EN, 32'h4 << i, `PIC_RESP_OKAY);
            chk("event raised", 32'h1, {31'h0, evt_irq});
            axi_wr(`PIC_OFS_EVT_CLR, 32'h4 << i, `PIC_RESP_OKAY);
            rd_chk("status clear", `PIC_OFS_EVT_STAT, 32'h0);
            chk("event cleared", 32'h0, {31'h0, evt_irq});
            axi_wr(`PIC_OFS_EVT_EN, 32'h0, `PIC_RESP_OKAY);
        end
        rd_chk("flags b", `PIC_OFS_CTRL_B, 32'hf0);
        rd_chk("flags c", `PIC_OFS_CTRL_C, 32'h30);
        $display("test events done");
        results();
    end
endmodule // pic_primary_irq_tb
`default_nettype wire
